// file: crb_defines.vh
// Register indices, field positions and reset values of the receive buffer readout
`ifndef CRB_DEFINES_VH
`define CRB_DEFINES_VH

// Register indices; byte address is four times the index
`define CRB_IDX_RX0_SIDH  7'h61
`define CRB_IDX_RX0_SIDL  7'h62
`define CRB_IDX_RX0_EIDH  7'h63
`define CRB_IDX_RX0_EIDL  7'h64
`define CRB_IDX_RX0_DLC   7'h65
`define CRB_IDX_RX0_D0    7'h66
`define CRB_IDX_RX1_SIDH  7'h71
`define CRB_IDX_RX1_SIDL  7'h72
`define CRB_IDX_RX1_EIDH  7'h73
`define CRB_IDX_RX1_EIDL  7'h74
`define CRB_IDX_RX1_DLC   7'h75
`define CRB_IDX_RX1_D0    7'h76
`define CRB_IDX_CTRL      7'h40
`define CRB_IDX_STAT      7'h41

// Offsets inside one buffer, counted from the index below the identifier-high byte
`define CRB_OFF_SIDH      4'h1
`define CRB_OFF_SIDL      4'h2
`define CRB_OFF_EIDH      4'h3
`define CRB_OFF_EIDL      4'h4
`define CRB_OFF_DLC       4'h5
`define CRB_OFF_D0        4'h6
`define CRB_OFF_D7        4'hD

// Identifier-low byte field positions
`define CRB_SIDL_STD_POS  5
`define CRB_SIDL_SRR_POS  4
`define CRB_SIDL_IDE_POS  3
`define CRB_SIDL_EXT_POS  0

// Length byte field positions
`define CRB_DLC_RTR_POS   6
`define CRB_DLC_RSV_POS   4
`define CRB_DLC_LEN_POS   0

// Control register bits and reset value
`define CRB_CTRL_EN0_POS  0
`define CRB_CTRL_EN1_POS  1
`define CRB_CTRL_RESET    8'h03

// Status register bits and reset value
`define CRB_STAT_FULL0_POS 0
`define CRB_STAT_FULL1_POS 1
`define CRB_STAT_OVF0_POS  2
`define CRB_STAT_OVF1_POS  3
`define CRB_STAT_RESET     4'h0

`endif

// file: crb_slot.v
// One receive message buffer with its byte read view
`timescale 1ns/100ps
`default_nettype none
`include "crb_defines.vh"

module crb_slot (
  input  wire        pclk,
  input  wire        load,
  input  wire [10:0] std_identifier,
  input  wire        srr,
  input  wire        ide,
  input  wire [17:0] ext_identifier,
  input  wire        rtr,
  input  wire        reserved_flag_one,
  input  wire        reserved_flag_zero,
  input  wire [3:0]  dlc,
  input  wire [63:0] data,
  input  wire [3:0]  rd_off,
  output reg  [7:0]  rd_byte
);

  reg  [10:0] std_id_r;
  reg         srr_r;
  reg         ide_r;
  reg  [17:0] ext_id_r;
  reg         rtr_r;
  reg  [1:0]  rsv_r;
  reg  [3:0]  dlc_r;
  reg  [7:0]  data_r [0:7];
  wire [3:0]  data_idx;
  integer     m;

  assign data_idx = rd_off - `CRB_OFF_D0;

  // Storage has no reset; contents are undefined until the first load
  always @(posedge pclk) begin
    if (load) begin
      std_id_r <= std_identifier;
      srr_r    <= srr;
      ide_r    <= ide;
      ext_id_r <= ext_identifier;
      rtr_r <= rtr;
      rsv_r <= {reserved_flag_one, reserved_flag_zero};
      dlc_r <= dlc;
      for (m = 0; m < 8; m = m + 1) begin
        data_r[m] <= data[8*m +: 8];
      end
    end
  end

  // Byte view of the stored frame
  always @* begin
    rd_byte = 8'h00;
    case (rd_off)
      `CRB_OFF_SIDH: rd_byte = std_id_r[10:3];
      `CRB_OFF_SIDL: begin
        rd_byte[`CRB_SIDL_STD_POS +: 3] = std_id_r[2:0];
        rd_byte[`CRB_SIDL_SRR_POS]      = srr_r;
        rd_byte[`CRB_SIDL_IDE_POS]      = ide_r;
        rd_byte[`CRB_SIDL_EXT_POS +: 2] = ext_id_r[17:16];
        rd_byte[2]                      = 1'b0;
      end
      `CRB_OFF_EIDH: rd_byte = ext_id_r[15:8];
      `CRB_OFF_EIDL: rd_byte = ext_id_r[7:0];
      `CRB_OFF_DLC: begin
        rd_byte[`CRB_DLC_RTR_POS]      = rtr_r;
        rd_byte[`CRB_DLC_RSV_POS +: 2] = rsv_r;
        rd_byte[`CRB_DLC_LEN_POS +: 4] = dlc_r;
        rd_byte[7]                     = 1'b0;
      end
      default: begin
        if (rd_off >= `CRB_OFF_D0 && rd_off <= `CRB_OFF_D7) begin
          rd_byte = data_r[data_idx[2:0]];
        end
      end
    endcase
  end

endmodule
`default_nettype wire

// file: crb_readout.v
// APB readout of the two receive message buffers
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "crb_defines.vh"

module crb_readout #(
  parameter ADDR_W = 9
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              rx0_load,
  input  wire [10:0]       rx0_std_identifier,
  input  wire              rx0_srr,
  input  wire              rx0_ide,
  input  wire [17:0]       rx0_ext_identifier,
  input  wire              rx0_rtr,
  input  wire              rx0_reserved_flag_one,
  input  wire              rx0_reserved_flag_zero,
  input  wire [3:0]        rx0_dlc,
  input  wire [63:0]       rx0_data,
  input  wire              rx1_load,
  input  wire [10:0]       rx1_std_identifier,
  input  wire              rx1_srr,
  input  wire              rx1_ide,
  input  wire [17:0]       rx1_ext_identifier,
  input  wire              rx1_rtr,
  input  wire              rx1_reserved_flag_one,
  input  wire              rx1_reserved_flag_zero,
  input  wire [3:0]        rx1_dlc,
  input  wire [63:0]       rx1_data,
  output wire              rx0_full,
  output wire              rx1_full
);

  // Word index of a buffer register: offset from base, or 0 when outside
  function [3:0] buf_off;
    input [6:0] idx;
    input [6:0] base;
    reg   [6:0] diff;
    begin
      diff = idx - base;
      if (idx > base && diff <= {3'b000, `CRB_OFF_D7}) begin
        buf_off = diff[3:0];
      end else begin
        buf_off = 4'h0;
      end
    end
  endfunction

  // Set-over-clear update of a sticky flag
  function sticky;
    input cur;
    input set;
    input clr;
    begin
      sticky = set | (cur & ~clr);
    end
  endfunction

  localparam [6:0] RX0_BASE = `CRB_IDX_RX0_SIDH - 7'h01;
  localparam [6:0] RX1_BASE = `CRB_IDX_RX1_SIDH - 7'h01;

  reg  [31:0] prdata_r;
  reg  [31:0] prdata_nxt;
  reg  [7:0]  ctrl_r;
  reg  [7:0]  ctrl_nxt;
  reg  [3:0]  stat_r;
  reg  [3:0]  stat_nxt;

  wire [6:0]  word_idx;
  wire        aligned;
  wire [3:0]  off0;
  wire [3:0]  off1;
  wire        hit0;
  wire        hit1;
  wire        hit_ctrl;
  wire        hit_stat;
  wire        mapped;
  wire        setup;
  wire        access;
  wire        wr_ctrl;
  wire        wr_stat;
  wire [7:0]  byte0;
  wire [7:0]  byte1;
  wire        en0;
  wire        en1;
  wire        take0;
  wire        take1;
  wire        lost0;
  wire        lost1;
  wire [3:0]  clr_stat;

  // Address decode
  assign word_idx = paddr[8:2];
  assign aligned  = (paddr[1:0] == 2'b00);
  assign off0     = buf_off(word_idx, RX0_BASE);
  assign off1     = buf_off(word_idx, RX1_BASE);
  assign hit0     = aligned && (off0 != 4'h0);
  assign hit1     = aligned && (off1 != 4'h0);
  assign hit_ctrl = aligned && (word_idx == `CRB_IDX_CTRL);
  assign hit_stat = aligned && (word_idx == `CRB_IDX_STAT);
  assign mapped   = hit0 | hit1 | hit_ctrl | hit_stat;

  // Bus phases; zero wait states
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_r;

  // Only the control and status words accept writes
  assign wr_ctrl  = access & pwrite & hit_ctrl;
  assign wr_stat  = access & pwrite & hit_stat;
  assign clr_stat = wr_stat ? pwdata[3:0] : 4'h0;

  // Frame acceptance per buffer
  assign en0   = ctrl_r[`CRB_CTRL_EN0_POS];
  assign en1   = ctrl_r[`CRB_CTRL_EN1_POS];
  assign take0 = rx0_load & en0 & ~stat_r[`CRB_STAT_FULL0_POS];
  assign take1 = rx1_load & en1 & ~stat_r[`CRB_STAT_FULL1_POS];
  assign lost0 = rx0_load & en0 & stat_r[`CRB_STAT_FULL0_POS];
  assign lost1 = rx1_load & en1 & stat_r[`CRB_STAT_FULL1_POS];

  assign rx0_full = stat_r[`CRB_STAT_FULL0_POS];
  assign rx1_full = stat_r[`CRB_STAT_FULL1_POS];

  // Buffer 0 storage
  crb_slot u_slot0 (
    .pclk               (pclk),
    .load               (take0),
    .std_identifier     (rx0_std_identifier),
    .srr                (rx0_srr),
    .ide                (rx0_ide),
    .ext_identifier     (rx0_ext_identifier),
    .rtr                (rx0_rtr),
    .reserved_flag_one  (rx0_reserved_flag_one),
    .reserved_flag_zero (rx0_reserved_flag_zero),
    .dlc                (rx0_dlc),
    .data               (rx0_data),
    .rd_off             (off0),
    .rd_byte            (byte0)
  );

  // Buffer 1 storage
  crb_slot u_slot1 (
    .pclk               (pclk),
    .load               (take1),
    .std_identifier     (rx1_std_identifier),
    .srr                (rx1_srr),
    .ide                (rx1_ide),
    .ext_identifier     (rx1_ext_identifier),
    .rtr                (rx1_rtr),
    .reserved_flag_one  (rx1_reserved_flag_one),
    .reserved_flag_zero (rx1_reserved_flag_zero),
    .dlc                (rx1_dlc),
    .data               (rx1_data),
    .rd_off             (off1),
    .rd_byte            (byte1)
  );

  // Read data captured in the setup phase
  always @* begin
    prdata_nxt = prdata_r;
    if (setup && !pwrite) begin
      prdata_nxt = 32'h00000000;
      if (hit0) begin
        prdata_nxt[7:0] = byte0;
      end else if (hit1) begin
        prdata_nxt[7:0] = byte1;
      end else if (hit_ctrl) begin
        prdata_nxt[7:0] = ctrl_r;
      end else if (hit_stat) begin
        prdata_nxt[3:0] = stat_r;
      end
    end
  end

  // Control register; buffer words take no write
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = {6'b000000, pwdata[1:0]};
    end
  end

  // Full and overflow flags; hardware set wins over a write-one clear
  always @* begin
    stat_nxt = stat_r;
    stat_nxt[`CRB_STAT_FULL0_POS] = sticky(stat_r[`CRB_STAT_FULL0_POS], take0,
                                           clr_stat[`CRB_STAT_FULL0_POS]);
    stat_nxt[`CRB_STAT_FULL1_POS] = sticky(stat_r[`CRB_STAT_FULL1_POS], take1,
                                           clr_stat[`CRB_STAT_FULL1_POS]);
    stat_nxt[`CRB_STAT_OVF0_POS]  = sticky(stat_r[`CRB_STAT_OVF0_POS], lost0,
                                           clr_stat[`CRB_STAT_OVF0_POS]);
    stat_nxt[`CRB_STAT_OVF1_POS]  = sticky(stat_r[`CRB_STAT_OVF1_POS], lost1,
                                           clr_stat[`CRB_STAT_OVF1_POS]);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      ctrl_r   <= `CRB_CTRL_RESET;
      stat_r   <= `CRB_STAT_RESET;
    end else begin
      prdata_r <= prdata_nxt;
      ctrl_r   <= ctrl_nxt;
      stat_r   <= stat_nxt;
    end
  end

endmodule
`default_nettype wire

// file: crb_readout_checker.sv
// Checker for the receive buffer readout
`timescale 1ns/100ps
`default_nettype none
module crb_readout_checker #(
  parameter ADDR_W = 9
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              rx0_load,
  input wire logic [10:0]       rx0_std_identifier,
  input wire logic              rx0_srr,
  input wire logic              rx0_ide,
  input wire logic [17:0]       rx0_ext_identifier,
  input wire logic              rx0_rtr,
  input wire logic              rx0_reserved_flag_one,
  input wire logic              rx0_reserved_flag_zero,
  input wire logic [3:0]        rx0_dlc,
  input wire logic [63:0]       rx0_data,
  input wire logic              rx0_full
);
  logic [7:0]  std_hi_r, std_lo_r, ext_hi_r, ext_lo_r, len_r;
  logic [63:0] dat_r;
  wire  [6:0]  idx;
  assign idx = paddr[ADDR_W-1:2];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Copy of the frame kept by buffer 0
  always_ff @(posedge pclk) begin
    if (rx0_load && !rx0_full) begin
      std_hi_r <= rx0_std_identifier[10:3];
      std_lo_r <= {rx0_std_identifier[2:0], rx0_srr, rx0_ide, 1'h0, rx0_ext_identifier[17:16]};
      ext_hi_r <= rx0_ext_identifier[15:8];
      ext_lo_r <= rx0_ext_identifier[7:0];
      len_r    <= {1'h0, rx0_rtr, rx0_reserved_flag_one, rx0_reserved_flag_zero, rx0_dlc};
      dat_r    <= rx0_data;
    end
  end
  sequence s_rd(logic [6:0] i);
    psel && !penable && !pwrite && idx == i && rx0_full;
  endsequence
  sequence s_wr;
    psel && penable && pwrite && idx >= 7'h61 && idx <= 7'h6D && paddr[1:0] == 2'b00;
  endsequence
  property p_std_hi;
    s_rd(7'h61) |=> prdata == {24'h0, std_hi_r};
  endproperty
  a_std_hi: assert property (p_std_hi) else $error("id high byte differs");
  property p_std_lo;
    s_rd(7'h62) |=> (prdata == {24'h0, std_lo_r}) [*2];
  endproperty
  a_std_lo: assert property (p_std_lo) else $error("id low byte differs");
  property p_ext_hi;
    s_rd(7'h63) |=> prdata == {24'h0, ext_hi_r};
  endproperty
  a_ext_hi: assert property (p_ext_hi) else $error("ext high byte differs");
  property p_ext_lo;
    s_rd(7'h64) |=> prdata == {24'h0, ext_lo_r};
  endproperty
  a_ext_lo: assert property (p_ext_lo) else $error("ext low byte differs");
  property p_len;
    s_rd(7'h65) |=> prdata == {24'h0, len_r};
  endproperty
  a_len: assert property (p_len) else $error("length byte differs");
  property p_dat;
    psel && !penable && !pwrite && idx >= 7'h66 && idx <= 7'h6D && rx0_full
      |=> prdata == {24'h0, dat_r[8*(idx-7'h66) +: 8]};
  endproperty
  a_dat: assert property (p_dat) else $error("data byte differs");
  property p_ro;
    s_wr |-> !pslverr;
  endproperty
  a_ro: assert property (p_ro) else $error("buffer write flagged");
  property p_gap;
    psel && penable && idx == 7'h6E |-> pslverr;
  endproperty
  a_gap: assert property (p_gap) else $error("word past data mapped");
endmodule
bind crb_readout crb_readout_checker #(.ADDR_W(ADDR_W)) crb_readout_checker_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr, .rx0_load,
  .rx0_std_identifier, .rx0_srr, .rx0_ide, .rx0_ext_identifier, .rx0_rtr,
  .rx0_reserved_flag_one, .rx0_reserved_flag_zero, .rx0_dlc, .rx0_data, .rx0_full
);
`default_nettype wire

// file: crb_frame_src.sv
// Frame source feeding one receive buffer
`timescale 1ns/100ps
`default_nettype none
module crb_frame_src (
  input  wire logic    pclk,
  output logic         load,
  output logic [101:0] f
);
  initial begin
    load = 1'h0;
    f = {102{1'h0}};
  end
  // One-cycle load; fields not held afterwards
  task automatic send(input logic [101:0] v);
    @(posedge pclk);
    load <= 1'h1;
    f <= v;
    @(posedge pclk);
    load <= 1'h0;
    f <= ~v;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the receive buffer readout
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic         pclk = 1'h0;
  logic         presetn = 1'h0;
  logic         psel = 1'h0;
  logic         penable = 1'h0;
  logic         pwrite = 1'h0;
  logic [8:0]   paddr = 9'h0;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  rd;
  logic         er;
  wire  [31:0]  prdata;
  wire          pready, pslverr, ld0, ld1, full0, full1;
  wire  [101:0] f0, f1;
  int           err_total = 0;
  int           samples_checked = 0;
  always #25 pclk = ~pclk;
  crb_frame_src src0_inst (.pclk, .load(ld0), .f(f0));
  crb_frame_src src1_inst (.pclk, .load(ld1), .f(f1));
  crb_readout #(.ADDR_W(9)) crb_readout_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx0_load(ld0), .rx0_std_identifier(f0[101:91]), .rx0_srr(f0[90]), .rx0_ide(f0[89]),
    .rx0_ext_identifier(f0[88:71]), .rx0_rtr(f0[70]), .rx0_reserved_flag_one(f0[69]),
    .rx0_reserved_flag_zero(f0[68]), .rx0_dlc(f0[67:64]), .rx0_data(f0[63:0]), .rx0_full(full0),
    .rx1_load(ld1), .rx1_std_identifier(f1[101:91]), .rx1_srr(f1[90]), .rx1_ide(f1[89]),
    .rx1_ext_identifier(f1[88:71]), .rx1_rtr(f1[70]), .rx1_reserved_flag_one(f1[69]),
    .rx1_reserved_flag_zero(f1[68]), .rx1_dlc(f1[67:64]), .rx1_data(f1[63:0]), .rx1_full(full1)
  );
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  // APB transfer on a word index
  task automatic apb(input logic w, input logic [6:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Load a frame, read all thirteen words, try a write, free the buffers
  task automatic load_and_check(input logic n, input logic [101:0] f);
    logic [7:0] e [13];
    logic [6:0] b;
    b = n ? 7'h71 : 7'h61;
    e[0] = f[101:94];
    e[1] = {f[93:89], 1'h0, f[88:87]};
    e[2] = f[86:79];
    e[3] = f[78:71];
    e[4] = {1'h0, f[70:64]};
    for (int i = 0; i < 8; i++) e[5+i] = f[8*i +: 8];
    if (n) src1_inst.send(f);
    else src0_inst.send(f);
    for (int i = 0; i < 13; i++) begin
      apb(1'h0, b + i[6:0], 32'h0);
      chk("buffer word", {24'h0, e[i]}, rd);
      chk("bus error", 32'h0, {31'h0, er});
    end
    chk("buffer full", 32'h1, {31'h0, n ? full1 : full0});
    apb(1'h1, b + 7'h1, 32'hFFFFFFFF);
    apb(1'h0, b + 7'h1, 32'h0);
    chk("word after write", {24'h0, e[1]}, rd);
    if (n) src1_inst.send(~f);
    else src0_inst.send(~f);
    apb(1'h0, 7'h41, 32'h0);
    chk("status while full", n ? 32'hA : 32'h5, rd);
    apb(1'h0, b, 32'h0);
    chk("word kept while full", {24'h0, e[0]}, rd);
    apb(1'h1, 7'h41, 32'hF);
    apb(1'h0, 7'h41, 32'h0);
    chk("status after clear", 32'h0, rd);
    chk("buffer freed", 32'h0, {31'h0, n ? full1 : full0});
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 7'h40, 32'h0);
    chk("control after reset", 32'h3, rd);
    apb(1'h1, 7'h40, 32'h0);
    src1_inst.send({11'h2AA, 2'h0, 18'h15555, 3'h0, 4'h2, 64'h0});
    apb(1'h0, 7'h41, 32'h0);
    chk("status after dropped load", 32'h0, rd);
    apb(1'h1, 7'h40, 32'h3);
    load_and_check(1'h0, {11'h5A3, 2'h2, 18'h2B4C7, 3'h4, 4'h8, 64'h8877665544332211});
    load_and_check(1'h1, {11'h15C, 2'h3, 18'h1E38F, 3'h5, 4'hF, 64'h0123456789ABCDEF});
    load_and_check(1'h0, {11'h7FF, 2'h1, 18'h3FFFF, 3'h3, 4'h0, 64'hF0E1D2C3B4A59687});
    apb(1'h0, 7'h6E, 32'h0);
    chk("past last data byte", 32'h1, {31'h0, er});
    tally_and_finish;
  end
  initial begin
    #(50 * 3000);
    err_total++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
